// >>> logic/scfg_consts.svh
`ifndef SCFG_CONSTS_SVH
`define SCFG_CONSTS_SVH

`define SCFG_GEN_ADDR      8'h03
`define SCFG_MODE_ADDR     8'h04
`define SCFG_GEN_RST       8'hD2
`define SCFG_MODE_RST      8'h80
`define SCFG_GEN_SHARED    8'h92
`define SCFG_MODE_MASK     8'hB0
`define SCFG_GEN_CRC_EN    7
`define SCFG_GEN_AUTO_ACK  5
`define SCFG_GEN_FILTER    4
`define SCFG_GEN_PASS      3
`define SCFG_GEN_PCLK_AUTO 1
`define SCFG_MODE_FAILSAFE 7
`define SCFG_MODE_CRC_CLR  5
`define SCFG_MODE_GATE     4

`endif

// >>> logic/scfg_pkg.sv
package scfg_pkg;

    typedef enum logic [0:0] {
        ACK_IDLE,
        ACK_WAIT
    } scfg_ack_e;

    typedef logic [7:0] scfg_byte_t;

endpackage

// >>> logic/scfg_regs.sv
// Functional notes
// - The back-channel CRC checker runs only while general configuration bit 7 is 1, reset 1.
// - With auto-acknowledge (bit 5, reset 0) set, remote writes are acknowledged at once.
// - With auto-acknowledge set, no remote not-acknowledge reaches the local master.
// - With filter (bit 4, reset 1) set, sync and enable pulses under two cycles are rejected.
// - With pass-through (bit 3, reset 0) set, alias-matching transactions are forwarded.
// - Auto-acknowledge and pass-through are kept per port, second copy chosen by port select.
// - With automatic clock (bit 1, reset 1) set, the internal oscillator is used without clock.
// - Mode bit 7 picks failsafe level, 0 high and 1 low, register reset 0x80.
// - CRC error counters are held clear while mode bit 5 is 1, which never self-clears.
// - Mode bit 4 gates RGB data with data enable, otherwise RGB passes unchanged.
`timescale 1ns/10ps
`include "scfg_consts.svh"

module scfg_regs #(
    parameter int RGB_W = 24
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic             reg_wr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_rd_i,
    input  wire logic             second_port_select_i,
    input  wire logic             remote_wr_i,
    input  wire logic             req_port_i,
    input  wire logic             far_done_i,
    input  wire logic             far_nack_i,
    input  wire logic             alias_match_i,
    input  wire logic             pclk_present_i,
    input  wire logic             data_enable_i,
    input  wire logic             horizontal_sync_i,
    input  wire logic             vertical_sync_i,
    input  wire logic [RGB_W-1:0] rgb_i,
    output logic [7:0]            reg_rdata_o,
    output logic                  reg_rvalid_o,
    output logic                  crc_check_en_o,
    output logic                  crc_count_clear_o,
    output logic [1:0]            auto_ack_o,
    output logic [1:0]            pass_through_o,
    output logic                  forward_o,
    output logic                  local_ack_o,
    output logic                  local_nack_o,
    output logic                  use_internal_osc_o,
    output logic                  failsafe_level_o,
    output logic                  data_enable_o,
    output logic                  horizontal_sync_o,
    output logic                  vertical_sync_o,
    output logic [RGB_W-1:0]      rgb_o
);

    scfg_pkg::scfg_byte_t  gen_q,  gen_d;
    scfg_pkg::scfg_byte_t  mode_q, mode_d;
    logic [1:0]            auto_ack_q, auto_ack_d;
    logic [1:0]            pass_q, pass_d;
    scfg_pkg::scfg_byte_t  rdata_q, rdata_d;
    logic                  rvalid_q, rvalid_d;
    logic                  osc_q, osc_d;
    logic                  fsafe_q, fsafe_d;
    logic                  fwd_q, fwd_d;
    scfg_pkg::scfg_ack_e   state_q, state_d;
    logic                  ack_q, ack_d;
    logic                  nack_q, nack_d;
    logic [2:0]            in_q, in_d;
    logic [2:0]            sync_q, sync_d;
    logic [RGB_W-1:0]      rgb_q, rgb_d;
    logic [2:0]            sync_in;

    function automatic scfg_pkg::scfg_byte_t read_reg(input logic [7:0] addr,
                                                      input logic       port);
        scfg_pkg::scfg_byte_t v;
        v = 8'h00;
        if (addr == `SCFG_GEN_ADDR) begin
            v = gen_q & `SCFG_GEN_SHARED;
            v[`SCFG_GEN_AUTO_ACK] = auto_ack_q[port];
            v[`SCFG_GEN_PASS] = pass_q[port];
        end else if (addr == `SCFG_MODE_ADDR) begin
            v = mode_q & `SCFG_MODE_MASK;
        end
        return v;
    endfunction

    assign sync_in = {vertical_sync_i, horizontal_sync_i, data_enable_i};

    // Register writes and reads
    always_comb begin
        gen_d      = gen_q;
        mode_d     = mode_q;
        auto_ack_d = auto_ack_q;
        pass_d     = pass_q;
        rdata_d    = rdata_q;
        rvalid_d   = reg_rd_i;
        if (reg_wr_i && reg_addr_i == `SCFG_GEN_ADDR) begin
            gen_d = reg_wdata_i & `SCFG_GEN_SHARED;
            auto_ack_d[second_port_select_i] = reg_wdata_i[`SCFG_GEN_AUTO_ACK];
            pass_d[second_port_select_i] = reg_wdata_i[`SCFG_GEN_PASS];
        end
        if (reg_wr_i && reg_addr_i == `SCFG_MODE_ADDR) begin
            mode_d = reg_wdata_i & `SCFG_MODE_MASK;
        end
        if (reg_rd_i) begin
            rdata_d = read_reg(reg_addr_i, second_port_select_i);
        end
    end

    // Derived controls
    always_comb begin
        osc_d   = gen_q[`SCFG_GEN_PCLK_AUTO] && !pclk_present_i;
        fsafe_d = !mode_q[`SCFG_MODE_FAILSAFE];
        fwd_d   = alias_match_i && pass_q[req_port_i];
    end

    // Remote write acknowledge
    always_comb begin
        state_d = state_q;
        ack_d   = 1'b0;
        nack_d  = 1'b0;
        unique case (state_q)
            scfg_pkg::ACK_IDLE: begin
                if (remote_wr_i) begin
                    if (auto_ack_q[req_port_i]) begin
                        ack_d = 1'b1;
                    end else begin
                        state_d = scfg_pkg::ACK_WAIT;
                    end
                end
            end
            scfg_pkg::ACK_WAIT: begin
                if (far_done_i) begin
                    ack_d   = !far_nack_i;
                    nack_d  = far_nack_i;
                    state_d = scfg_pkg::ACK_IDLE;
                end
            end
        endcase
    end

    // Two-cycle glitch filter and RGB gating
    always_comb begin
        in_d = sync_in;
        if (gen_q[`SCFG_GEN_FILTER]) begin
            sync_d = (~(sync_in ^ in_q) & sync_in) | ((sync_in ^ in_q) & sync_q);
        end else begin
            sync_d = sync_in;
        end
        if (mode_q[`SCFG_MODE_GATE] && !data_enable_i) begin
            rgb_d = '0;
        end else begin
            rgb_d = rgb_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            gen_q      <= `SCFG_GEN_RST & `SCFG_GEN_SHARED;
            mode_q     <= `SCFG_MODE_RST;
            auto_ack_q <= {2{1'b0}};
            pass_q     <= {2{1'b0}};
            rdata_q    <= 8'h00;
            rvalid_q   <= 1'b0;
            osc_q      <= 1'b0;
            fsafe_q    <= 1'b0;
            fwd_q      <= 1'b0;
            state_q    <= scfg_pkg::ACK_IDLE;
            ack_q      <= 1'b0;
            nack_q     <= 1'b0;
            in_q       <= 3'h0;
            sync_q     <= 3'h0;
            rgb_q      <= '0;
        end else begin
            gen_q      <= gen_d;
            mode_q     <= mode_d;
            auto_ack_q <= auto_ack_d;
            pass_q     <= pass_d;
            rdata_q    <= rdata_d;
            rvalid_q   <= rvalid_d;
            osc_q      <= osc_d;
            fsafe_q    <= fsafe_d;
            fwd_q      <= fwd_d;
            state_q    <= state_d;
            ack_q      <= ack_d;
            nack_q     <= nack_d;
            in_q       <= in_d;
            sync_q     <= sync_d;
            rgb_q      <= rgb_d;
        end
    end

    assign reg_rdata_o        = rdata_q;
    assign reg_rvalid_o       = rvalid_q;
    assign crc_check_en_o     = gen_q[`SCFG_GEN_CRC_EN];
    assign crc_count_clear_o  = mode_q[`SCFG_MODE_CRC_CLR];
    assign auto_ack_o         = auto_ack_q;
    assign pass_through_o     = pass_q;
    assign forward_o          = fwd_q;
    assign local_ack_o        = ack_q;
    assign local_nack_o       = nack_q;
    assign use_internal_osc_o = osc_q;
    assign failsafe_level_o   = fsafe_q;
    assign data_enable_o      = sync_q[0];
    assign horizontal_sync_o  = sync_q[1];
    assign vertical_sync_o    = sync_q[2];
    assign rgb_o              = rgb_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_crc_check_write: assert property (
        reg_wr_i && reg_addr_i == `SCFG_GEN_ADDR
        |=> crc_check_en_o == $past(reg_wdata_i[7]))
        else $error("CRC checker enable does not follow write");

    a_auto_ack_now: assert property (
        state_q == scfg_pkg::ACK_IDLE && remote_wr_i && auto_ack_q[req_port_i]
        |=> local_ack_o && !local_nack_o)
        else $error("Auto acknowledge not given next cycle");

    a_no_nack_idle: assert property (
        state_q == scfg_pkg::ACK_IDLE |=> !local_nack_o)
        else $error("Not-acknowledge passed outside a waited write");

    a_filter_two_cycle: assert property (
        $past(gen_q[4]) && $changed(data_enable_o)
        |-> $past(data_enable_i) == data_enable_o && $past(data_enable_i, 2) == data_enable_o)
        else $error("Short enable pulse passed the filter");

    a_forward_gate: assert property (
        forward_o |-> $past(alias_match_i && pass_q[req_port_i]))
        else $error("Forward without pass-through and alias match");

    a_port_copy: assert property (
        reg_wr_i && reg_addr_i == `SCFG_GEN_ADDR && second_port_select_i
        |=> auto_ack_o[1] == $past(reg_wdata_i[5]) && auto_ack_o[0] == $past(auto_ack_o[0]))
        else $error("Port select did not steer write");

    a_osc_switch: assert property (
        1'b1 |=> use_internal_osc_o == $past(gen_q[1] && !pclk_present_i))
        else $error("Oscillator switch wrong");

    a_failsafe_level: assert property (
        reg_wr_i && reg_addr_i == `SCFG_MODE_ADDR
        |=> ##1 failsafe_level_o == !$past(reg_wdata_i[7], 2))
        else $error("Failsafe level wrong after write");

    a_crc_clear_hold: assert property (
        crc_count_clear_o && !(reg_wr_i && reg_addr_i == `SCFG_MODE_ADDR)
        |=> crc_count_clear_o)
        else $error("Counter clear dropped without a write");

    a_rgb_gate: assert property (
        mode_q[4] && !data_enable_i |=> rgb_o == '0)
        else $error("RGB not gated by data enable");

    a_reserved_zero: assert property (
        reg_rvalid_o |-> reg_rdata_o[6] == 1'b0 && reg_rdata_o[2] == 1'b0
                         && reg_rdata_o[0] == 1'b0)
        else $error("Reserved bit read as one");

    c_auto_ack: cover property (remote_wr_i && auto_ack_q[req_port_i]);
    c_far_nack: cover property (state_q == scfg_pkg::ACK_WAIT && far_done_i && far_nack_i);
    c_port1_read: cover property (reg_rd_i && second_port_select_i);
    c_filter_reject: cover property (gen_q[4] && $rose(data_enable_i) ##1 !data_enable_i);

endmodule

// >>> verif/scfg_far_model.sv
`timescale 1ns/10ps
module scfg_far_model (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic remote_wr_i,
    input  wire logic nack_i,
    input  wire logic [31:0] dly_i,
    output logic      far_done_o,
    output logic      far_nack_o
);
    int cnt;
    // Answers each remote write after dly_i cycles; nack line toggles when idle
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt        <= 0;
            far_done_o <= 1'b0;
            far_nack_o <= 1'b0;
        end else if (remote_wr_i) begin
            cnt        <= dly_i;
            far_done_o <= 1'b0;
            far_nack_o <= ~far_nack_o;
        end else if (cnt == 1) begin
            far_done_o <= 1'b1;
            far_nack_o <= nack_i;
            cnt        <= 0;
        end else begin
            far_done_o <= 1'b0;
            far_nack_o <= ~far_nack_o;
            if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic        core_clk_i, reset_i, reg_wr_i, reg_rd_i, second_port_select_i, nack_cfg;
    logic        remote_wr_i, req_port_i, far_done_i, far_nack_i, alias_match_i, a, n;
    logic        pclk_present_i, data_enable_i, horizontal_sync_i, vertical_sync_i;
    logic        reg_rvalid_o, crc_check_en_o, crc_count_clear_o, forward_o;
    logic        local_ack_o, local_nack_o, use_internal_osc_o, failsafe_level_o;
    logic        data_enable_o, horizontal_sync_o, vertical_sync_o;
    logic [1:0]  auto_ack_o, pass_through_o;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [23:0] rgb_i, rgb_o;
    logic [7:0]  exp_q[$];
    int          error_cnt, comparisons, seed, dly, k;
    scfg_regs #(.RGB_W(24)) i_scfg_regs (.core_clk_i, .reset_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rd_i, .second_port_select_i, .remote_wr_i, .req_port_i,
        .far_done_i, .far_nack_i, .alias_match_i, .pclk_present_i, .data_enable_i,
        .horizontal_sync_i, .vertical_sync_i, .rgb_i, .reg_rdata_o, .reg_rvalid_o,
        .crc_check_en_o, .crc_count_clear_o, .auto_ack_o, .pass_through_o, .forward_o,
        .local_ack_o, .local_nack_o, .use_internal_osc_o, .failsafe_level_o,
        .data_enable_o, .horizontal_sync_o, .vertical_sync_o, .rgb_o);
    scfg_far_model i_scfg_far_model (.core_clk_i, .reset_i, .remote_wr_i,
        .nack_i(nack_cfg), .dly_i(dly), .far_done_o(far_done_i), .far_nack_o(far_nack_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge core_clk_i);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = ad;
        reg_wdata_i = d;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(negedge core_clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = ad;
        exp_q.push_back(e);
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
    endtask
    task automatic req(input logic p);
        @(negedge core_clk_i);
        req_port_i = p;
        remote_wr_i = 1'b1;
        for (k = 1; k <= 20; k++) begin
            @(negedge core_clk_i);
            remote_wr_i = 1'b0;
            a = local_ack_o;
            n = local_nack_o;
            if (a === 1'b1 || n === 1'b1) break;
        end
    endtask
    task automatic sync_pulse(input int c, input int w, input logic [2:0] e);
        {data_enable_i, horizontal_sync_i, vertical_sync_i} = 3'h7;
        cyc(c);
        {data_enable_i, horizontal_sync_i, vertical_sync_i} = 3'h0;
        cyc(w);
        chk({data_enable_o, horizontal_sync_o, vertical_sync_o}, e);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(negedge core_clk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            chk(reg_rdata_o, exp_q.pop_front());
        end
    end
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {reset_i, pclk_present_i, nack_cfg} = 3'h7;
        {reg_wr_i, reg_rd_i, second_port_select_i, remote_wr_i, req_port_i} = 5'h00;
        {alias_match_i, data_enable_i, horizontal_sync_i, vertical_sync_i} = 4'h0;
        {reg_addr_i, reg_wdata_i, rgb_i} = 40'h0;
        {error_cnt, comparisons, seed, dly} = {32'd0, 32'd0, 32'd17187, 32'd5};
        cyc(6);
        reset_i = 1'b0;
        rd(8'h03, 8'h92);
        rd(8'h04, 8'h80);
        rd(8'h05, 8'h00);
        chk(crc_check_en_o, 1'b1);
        chk(failsafe_level_o, 1'b0);
        chk(use_internal_osc_o, 1'b0);
        pclk_present_i = 1'b0;
        cyc(2);
        chk(use_internal_osc_o, 1'b1);
        $display("test reset done");
        wr(8'h03, 8'hFF);
        chk({auto_ack_o, pass_through_o}, 4'h5);
        rd(8'h03, 8'hBA);
        second_port_select_i = 1'b1;
        wr(8'h03, 8'h08);
        cyc(1);
        chk({crc_check_en_o, use_internal_osc_o, pass_through_o}, 4'h3);
        rd(8'h03, 8'h08);
        second_port_select_i = 1'b0;
        rd(8'h03, 8'h28);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'hB0);
        cyc(5);
        chk({crc_count_clear_o, failsafe_level_o}, 2'h2);
        wr(8'h04, 8'h10);
        cyc(1);
        chk({crc_count_clear_o, failsafe_level_o}, 2'h1);
        $display("test registers done");
        wr(8'h03, 8'h22);
        alias_match_i = 1'b1;
        cyc(1);
        chk(forward_o, 1'b0);
        req_port_i = 1'b1;
        cyc(1);
        chk({forward_o, use_internal_osc_o}, 2'h3);
        alias_match_i = 1'b0;
        req(1'b0);
        chk({a, n, k[3:0]}, 6'h21);
        n = 1'b0;
        repeat (10) @(negedge core_clk_i) n = n | local_nack_o;
        chk(n, 1'b0);
        req(1'b1);
        chk({a, n, k > 3}, 3'h3);
        {nack_cfg, dly} = {1'b0, 32'd1};
        req(1'b1);
        chk({a, n}, 2'h2);
        $display("test acknowledge done");
        sync_pulse(1, 0, 3'h7);
        wr(8'h03, 8'h32);
        sync_pulse(1, 3, 3'h0);
        sync_pulse(3, 0, 3'h7);
        $display("test filter done");
        rgb_i = 24'($random(seed));
        cyc(1);
        chk(rgb_o, 24'h0);
        data_enable_i = 1'b1;
        cyc(1);
        chk(rgb_o, rgb_i);
        wr(8'h04, 8'h00);
        data_enable_i = 1'b0;
        rgb_i = 24'($random(seed));
        cyc(1);
        chk(rgb_o, rgb_i);
        $display("test gating done");
        cyc(2);
        report_and_stop();
    end
endmodule
